// file: pin_func_pkg.sv
// Constants for the port 0 / port 1 pin function multiplexer
package pin_func_pkg;
    // Pin slots and register port geometry
    localparam int NUM_PINS = 12;
    localparam int ADDR_W = 4;
    localparam int NUM_IRQ = 16;
    // Pin slot indices, also the register addresses
    localparam int PIN_P00 = 0;
    localparam int PIN_P01 = 1;
    localparam int PIN_P02 = 2;
    localparam int PIN_P03 = 3;
    localparam int PIN_P05 = 4;
    localparam int PIN_P07 = 5;
    localparam int PIN_P12 = 6;
    localparam int PIN_P13 = 7;
    localparam int PIN_P14 = 8;
    localparam int PIN_P15 = 9;
    localparam int PIN_P16 = 10;
    localparam int PIN_P17 = 11;
    localparam logic [ADDR_W-1:0] PIN_ADDR [NUM_PINS] = '{
        4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb};
    localparam logic [ADDR_W-1:0] LAST_REG_ADDR = 4'hb;
    // External interrupt line fed by each pin slot
    localparam logic [3:0] IRQ_LINE [NUM_PINS] = '{
        4'h8, 4'h9, 4'ha, 4'hb, 4'hd, 4'hf, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7};
    // Register field layout and reset value
    localparam int SEL_LSB = 0;
    localparam int SEL_W = 6;
    localparam int IRQ_EN_BIT = 6;
    localparam int ANALOG_BIT = 7;
    localparam logic [7:0] REG_RESET = 8'h00;
    // Selector codes
    localparam logic [SEL_W-1:0] CODE_HIZ = 6'h00;
    localparam logic [SEL_W-1:0] CODE_TIMER = 6'h05;
    localparam logic [SEL_W-1:0] CODE_ADC_MTU = 6'h08;
    localparam logic [SEL_W-1:0] CODE_SERIAL_A = 6'h0a;
    localparam logic [SEL_W-1:0] CODE_SERIAL_B = 6'h0b;
    localparam logic [SEL_W-1:0] CODE_SPI = 6'h0d;
    localparam logic [SEL_W-1:0] CODE_I2C = 6'h0f;
    localparam logic [SEL_W-1:0] CODE_CAN = 6'h10;
    // Peripheral input slots routed from pins
    localparam int NUM_PERIPH_IN = 14;
    localparam int IN_TMR0_RST = 0;
    localparam int IN_TMR0_CLK = 1;
    localparam int IN_TMR2_CLK = 2;
    localparam int IN_SER6_RX = 3;
    localparam int IN_SER1_RX = 4;
    localparam int IN_SER1_CLK = 5;
    localparam int IN_SER3_RX = 6;
    localparam int IN_SER3_CLK = 7;
    localparam int IN_CAN_RX = 8;
    localparam int IN_ADC_TRG_N = 9;
    localparam int IN_SPI_MISO = 10;
    localparam int IN_I2C_CLK = 11;
    localparam int IN_I2C_DATA = 12;
    localparam int IN_MTU_4B = 13;
    // Idle level of peripheral inputs when no pin feeds them
    localparam logic [NUM_PERIPH_IN-1:0] PERIPH_IDLE = 14'h0200;
endpackage

// file: port01_pin_function_select.sv
// Pin function multiplexer for port 0 and port 1 pins
`timescale 1ns/1ps
module port01_pin_function_select
    import pin_func_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdata,
    // Package pins
    input wire logic [NUM_PINS-1:0] pinIn,
    output logic [NUM_PINS-1:0] pinOut,
    output logic [NUM_PINS-1:0] pinOe,
    // Peripheral signals driven toward pins
    input wire logic serial6Transmit,
    input wire logic serial6TransmitOe,
    input wire logic serial1Transmit,
    input wire logic serial1TransmitOe,
    input wire logic serial1ClockOut,
    input wire logic serial1ClockOe,
    input wire logic serial3Transmit,
    input wire logic serial3TransmitOe,
    input wire logic serial3ClockOut,
    input wire logic serial3ClockOe,
    input wire logic spiMasterOut,
    input wire logic spiMasterOutOe,
    input wire logic i2c2ClockOut,
    input wire logic i2c2ClockOe,
    input wire logic i2c2DataOut,
    input wire logic i2c2DataOe,
    input wire logic multitimer4bOut,
    input wire logic multitimer4bOe,
    // Peripheral inputs taken from pins
    output logic timer8Ch0ResetIn,
    output logic timer8Ch0ClockIn,
    output logic timer8Ch2ClockIn,
    output logic serial6Receive,
    output logic serial1Receive,
    output logic serial1ClockIn,
    output logic serial3Receive,
    output logic serial3ClockIn,
    output logic canReceive,
    output logic adcTrigger0N,
    output logic spiMasterIn,
    output logic i2c2ClockIn,
    output logic i2c2DataIn,
    output logic multitimer4bIn,
    // External interrupt request lines
    output logic [NUM_IRQ-1:0] externalIrqLine
);

    logic rstMeta;
    logic rstN;
    logic [7:0] cfgReg [NUM_PINS];
    logic [NUM_PINS-1:0] pinMeta;
    logic [NUM_PINS-1:0] pinSync;
    logic [SEL_W-1:0] pinSel [NUM_PINS];
    logic [NUM_PINS-1:0] irqEn;
    logic [NUM_PINS-1:0] analogEn;
    logic [NUM_PINS-1:0] drvOut;
    logic [NUM_PINS-1:0] drvOe;
    logic [NUM_PERIPH_IN-1:0] periphNext;
    logic [NUM_PERIPH_IN-1:0] periphReg;
    logic [NUM_IRQ-1:0] irqNext;
    logic addrHit;
    logic [7:0] rdataNext;

    // Selector match, digital routing only while analog use is off
    function automatic logic selIs(input logic [SEL_W-1:0] sel, input logic ana,
                                   input logic [SEL_W-1:0] code);
        return !ana && (sel == code);
    endfunction

    // Reset release through two flops
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rstMeta <= 1'b0;
            rstN <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstN <= rstMeta;
        end
    end

    // Pin input synchroniser
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            pinMeta <= '0;
            pinSync <= '0;
        end else begin
            pinMeta <= pinIn;
            pinSync <= pinMeta;
        end
    end

    // Function control registers, one per pin slot
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_cfg
            always_ff @(posedge clk or negedge rstN) begin
                if (!rstN) begin
                    cfgReg[gi] <= REG_RESET;
                end else if (regWrite && regAddr == PIN_ADDR[gi]) begin
                    cfgReg[gi] <= regWdata;
                end
            end
            assign pinSel[gi] = cfgReg[gi][SEL_LSB +: SEL_W];
            assign irqEn[gi] = cfgReg[gi][IRQ_EN_BIT];
            assign analogEn[gi] = cfgReg[gi][ANALOG_BIT];
            // Interrupt line gated by the enable bit
            assign irqNext[IRQ_LINE[gi]] = irqEn[gi] & pinSync[gi];
        end
    endgenerate

    // Lines with no pin in this block stay low
    assign irqNext[0] = 1'b0;
    assign irqNext[1] = 1'b0;
    assign irqNext[12] = 1'b0;
    assign irqNext[14] = 1'b0;

    // Register read decode, unmapped addresses read zero
    assign addrHit = regAddr <= LAST_REG_ADDR;
    assign rdataNext = (regRead && addrHit) ? cfgReg[regAddr] : 8'h00;

    // Pins with no driving function in this block stay undriven
    assign drvOut[PIN_P01] = 1'b0;
    assign drvOe[PIN_P01] = 1'b0;
    assign drvOut[PIN_P02] = 1'b0;
    assign drvOe[PIN_P02] = 1'b0;
    assign drvOut[PIN_P03] = 1'b0;
    assign drvOe[PIN_P03] = 1'b0;
    assign drvOut[PIN_P05] = 1'b0;
    assign drvOe[PIN_P05] = 1'b0;
    assign drvOut[PIN_P07] = 1'b0;
    assign drvOe[PIN_P07] = 1'b0;
    assign drvOut[PIN_P12] = 1'b0;
    assign drvOe[PIN_P12] = 1'b0;
    assign drvOut[PIN_P13] = 1'b0;
    assign drvOe[PIN_P13] = 1'b0;
    assign drvOut[PIN_P14] = 1'b0;
    assign drvOe[PIN_P14] = 1'b0;

    // P00 output: serial6 transmit only
    assign drvOut[PIN_P00] = serial6Transmit;
    assign drvOe[PIN_P00] = selIs(pinSel[PIN_P00], analogEn[PIN_P00], CODE_SERIAL_A)
                            & serial6TransmitOe;

    // P15 output: serial3 clock only
    assign drvOut[PIN_P15] = serial3ClockOut;
    assign drvOe[PIN_P15] = selIs(pinSel[PIN_P15], analogEn[PIN_P15], CODE_SERIAL_B)
                            & serial3ClockOe;

    // P16 output select, other codes leave it undriven
    assign drvOut[PIN_P16] =
        selIs(pinSel[PIN_P16], analogEn[PIN_P16], CODE_SERIAL_A) ? serial1Transmit :
        selIs(pinSel[PIN_P16], analogEn[PIN_P16], CODE_SPI) ? spiMasterOut :
        selIs(pinSel[PIN_P16], analogEn[PIN_P16], CODE_I2C) ? i2c2ClockOut : 1'b0;
    assign drvOe[PIN_P16] =
        selIs(pinSel[PIN_P16], analogEn[PIN_P16], CODE_SERIAL_A) ? serial1TransmitOe :
        selIs(pinSel[PIN_P16], analogEn[PIN_P16], CODE_SPI) ? spiMasterOutOe :
        selIs(pinSel[PIN_P16], analogEn[PIN_P16], CODE_I2C) ? i2c2ClockOe : 1'b0;

    // P17 output select, other codes leave it undriven
    assign drvOut[PIN_P17] =
        selIs(pinSel[PIN_P17], analogEn[PIN_P17], CODE_ADC_MTU) ? multitimer4bOut :
        selIs(pinSel[PIN_P17], analogEn[PIN_P17], CODE_SERIAL_A) ? serial1ClockOut :
        selIs(pinSel[PIN_P17], analogEn[PIN_P17], CODE_SERIAL_B) ? serial3Transmit :
        selIs(pinSel[PIN_P17], analogEn[PIN_P17], CODE_I2C) ? i2c2DataOut : 1'b0;
    assign drvOe[PIN_P17] =
        selIs(pinSel[PIN_P17], analogEn[PIN_P17], CODE_ADC_MTU) ? multitimer4bOe :
        selIs(pinSel[PIN_P17], analogEn[PIN_P17], CODE_SERIAL_A) ? serial1ClockOe :
        selIs(pinSel[PIN_P17], analogEn[PIN_P17], CODE_SERIAL_B) ? serial3TransmitOe :
        selIs(pinSel[PIN_P17], analogEn[PIN_P17], CODE_I2C) ? i2c2DataOe : 1'b0;

    // Peripheral inputs, idle level when not routed
    assign periphNext[IN_TMR0_RST] =
        selIs(pinSel[PIN_P00], analogEn[PIN_P00], CODE_TIMER) & pinSync[PIN_P00];
    assign periphNext[IN_TMR0_CLK] =
        selIs(pinSel[PIN_P01], analogEn[PIN_P01], CODE_TIMER) & pinSync[PIN_P01];
    assign periphNext[IN_SER6_RX] =
        selIs(pinSel[PIN_P01], analogEn[PIN_P01], CODE_SERIAL_A) & pinSync[PIN_P01];
    assign periphNext[IN_TMR2_CLK] =
        selIs(pinSel[PIN_P15], analogEn[PIN_P15], CODE_TIMER) & pinSync[PIN_P15];
    assign periphNext[IN_SER1_RX] =
        selIs(pinSel[PIN_P15], analogEn[PIN_P15], CODE_SERIAL_A) & pinSync[PIN_P15];
    assign periphNext[IN_SER3_CLK] =
        selIs(pinSel[PIN_P15], analogEn[PIN_P15], CODE_SERIAL_B) & pinSync[PIN_P15];
    assign periphNext[IN_CAN_RX] =
        selIs(pinSel[PIN_P15], analogEn[PIN_P15], CODE_CAN) & pinSync[PIN_P15];
    assign periphNext[IN_ADC_TRG_N] =
        !selIs(pinSel[PIN_P16], analogEn[PIN_P16], CODE_ADC_MTU) | pinSync[PIN_P16];
    assign periphNext[IN_SER3_RX] =
        selIs(pinSel[PIN_P16], analogEn[PIN_P16], CODE_SERIAL_B) & pinSync[PIN_P16];
    assign periphNext[IN_I2C_CLK] =
        selIs(pinSel[PIN_P16], analogEn[PIN_P16], CODE_I2C) & pinSync[PIN_P16];
    assign periphNext[IN_MTU_4B] =
        selIs(pinSel[PIN_P17], analogEn[PIN_P17], CODE_ADC_MTU) & pinSync[PIN_P17];
    assign periphNext[IN_SER1_CLK] =
        selIs(pinSel[PIN_P17], analogEn[PIN_P17], CODE_SERIAL_A) & pinSync[PIN_P17];
    assign periphNext[IN_SPI_MISO] =
        selIs(pinSel[PIN_P17], analogEn[PIN_P17], CODE_SPI) & pinSync[PIN_P17];
    assign periphNext[IN_I2C_DATA] =
        selIs(pinSel[PIN_P17], analogEn[PIN_P17], CODE_I2C) & pinSync[PIN_P17];

    // Output flops for pins, peripheral inputs, interrupts and read data
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            pinOut <= '0;
            pinOe <= '0;
            periphReg <= PERIPH_IDLE;
            externalIrqLine <= '0;
            regRdata <= 8'h00;
        end else begin
            pinOut <= drvOut;
            pinOe <= drvOe;
            periphReg <= periphNext;
            externalIrqLine <= irqNext;
            regRdata <= rdataNext;
        end
    end

    // Peripheral input ports
    assign timer8Ch0ResetIn = periphReg[IN_TMR0_RST];
    assign timer8Ch0ClockIn = periphReg[IN_TMR0_CLK];
    assign timer8Ch2ClockIn = periphReg[IN_TMR2_CLK];
    assign serial6Receive = periphReg[IN_SER6_RX];
    assign serial1Receive = periphReg[IN_SER1_RX];
    assign serial1ClockIn = periphReg[IN_SER1_CLK];
    assign serial3Receive = periphReg[IN_SER3_RX];
    assign serial3ClockIn = periphReg[IN_SER3_CLK];
    assign canReceive = periphReg[IN_CAN_RX];
    assign adcTrigger0N = periphReg[IN_ADC_TRG_N];
    assign spiMasterIn = periphReg[IN_SPI_MISO];
    assign i2c2ClockIn = periphReg[IN_I2C_CLK];
    assign i2c2DataIn = periphReg[IN_I2C_DATA];
    assign multitimer4bIn = periphReg[IN_MTU_4B];

    // Checks on routing behaviour
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstN);

    sequence s_p05HighEnabled;
        pinIn[PIN_P05] && irqEn[PIN_P05] [*3];
    endsequence

    sequence s_p16Spi;
        pinSel[PIN_P16] == CODE_SPI && !analogEn[PIN_P16];
    endsequence

    property p_hizQuiet;
        pinSel[PIN_P17] == CODE_HIZ |=> !pinOe[PIN_P17] && !multitimer4bIn;
    endproperty
    a_hizQuiet: assert property (p_hizQuiet) else $error("hi-z pin driven");

    property p_p00Serial6;
        selIs(pinSel[PIN_P00], analogEn[PIN_P00], CODE_SERIAL_A)
        |=> pinOe[PIN_P00] == $past(serial6TransmitOe)
            && pinOut[PIN_P00] == $past(serial6Transmit);
    endproperty
    a_p00Serial6: assert property (p_p00Serial6) else $error("P00 tx routing");

    property p_p00Timer;
        selIs(pinSel[PIN_P00], analogEn[PIN_P00], CODE_TIMER)
        |=> timer8Ch0ResetIn == $past(pinSync[PIN_P00]) && !pinOe[PIN_P00];
    endproperty
    a_p00Timer: assert property (p_p00Timer) else $error("P00 timer routing");

    property p_p01Timer;
        selIs(pinSel[PIN_P01], analogEn[PIN_P01], CODE_TIMER)
        |=> timer8Ch0ClockIn == $past(pinSync[PIN_P01]) && !serial6Receive;
    endproperty
    a_p01Timer: assert property (p_p01Timer) else $error("P01 timer routing");

    property p_p01Serial6;
        selIs(pinSel[PIN_P01], analogEn[PIN_P01], CODE_SERIAL_A)
        |=> serial6Receive == $past(pinSync[PIN_P01]) && !timer8Ch0ClockIn;
    endproperty
    a_p01Serial6: assert property (p_p01Serial6) else $error("P01 rx routing");

    property p_irqBlocked;
        !irqEn[PIN_P12] |=> !externalIrqLine[2];
    endproperty
    a_irqBlocked: assert property (p_irqBlocked) else $error("irq not gated");

    property p_p05IrqLatency;
        s_p05HighEnabled |=> externalIrqLine[13];
    endproperty
    a_p05IrqLatency: assert property (p_p05IrqLatency) else $error("P05 irq late");

    property p_p15Can;
        selIs(pinSel[PIN_P15], analogEn[PIN_P15], CODE_CAN)
        |=> canReceive == $past(pinSync[PIN_P15]) && !timer8Ch2ClockIn;
    endproperty
    a_p15Can: assert property (p_p15Can) else $error("P15 CAN routing");

    property p_p15Serial3Clk;
        selIs(pinSel[PIN_P15], analogEn[PIN_P15], CODE_SERIAL_B)
        |=> pinOe[PIN_P15] == $past(serial3ClockOe)
            && serial3ClockIn == $past(pinSync[PIN_P15]);
    endproperty
    a_p15Serial3Clk: assert property (p_p15Serial3Clk) else $error("P15 clock routing");

    property p_p16Spi;
        s_p16Spi |=> pinOut[PIN_P16] == $past(spiMasterOut)
                     && pinOe[PIN_P16] == $past(spiMasterOutOe);
    endproperty
    a_p16Spi: assert property (p_p16Spi) else $error("P16 SPI routing");

    property p_p16Adc;
        selIs(pinSel[PIN_P16], analogEn[PIN_P16], CODE_ADC_MTU)
        |=> adcTrigger0N == $past(pinSync[PIN_P16]) && !pinOe[PIN_P16];
    endproperty
    a_p16Adc: assert property (p_p16Adc) else $error("P16 trigger routing");

    property p_p17Timer4b;
        selIs(pinSel[PIN_P17], analogEn[PIN_P17], CODE_ADC_MTU)
        |=> multitimer4bIn == $past(pinSync[PIN_P17])
            && pinOe[PIN_P17] == $past(multitimer4bOe);
    endproperty
    a_p17Timer4b: assert property (p_p17Timer4b) else $error("P17 timer routing");

    property p_p14Irq;
        irqEn[PIN_P14] |=> externalIrqLine[4] == $past(pinSync[PIN_P14]);
    endproperty
    a_p14Irq: assert property (p_p14Irq) else $error("P14 irq routing");

    property p_reservedCode;
        pinSel[PIN_P16] == 6'h3f |=> !pinOe[PIN_P16] && adcTrigger0N && !i2c2ClockIn;
    endproperty
    a_reservedCode: assert property (p_reservedCode) else $error("reserved code live");

endmodule // port01_pin_function_select

// file: pin_periph_model.sv
// Model of the package pins and on-chip peripheral drivers around the multiplexer
`timescale 1ns/1ps
module pin_periph_model
    import pin_func_pkg::*;
(
    // Clock
    input wire logic clk,
    // Bench controls
    input wire logic [NUM_PINS-1:0] extLevel,
    input wire logic [8:0] drvVal,
    input wire logic [8:0] drvOe,
    // Multiplexer side
    input wire logic [NUM_PINS-1:0] pinOut,
    input wire logic [NUM_PINS-1:0] pinOe,
    output logic [NUM_PINS-1:0] pinIn,
    output logic [8:0] periphOut,
    output logic [8:0] periphOe
);
    logic toggle = 1'b0;

    // Wire level: device drive wins, else the outside part's level
    // Undriven pins read as plain inputs, as capture inputs need
    assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);

    // Peripheral drivers; a released data line shows a changing pattern
    assign periphOe = drvOe;
    assign periphOut = (drvOe & drvVal) | (~drvOe & {9{toggle}});

    // Pattern source for released lines
    always @(posedge clk) begin
        toggle <= ~toggle;
    end
endmodule // pin_periph_model

// file: port01_pin_function_select_bench.sv
// Self-checking testbench for the port 0 / port 1 pin function multiplexer
`timescale 1ns/1ps
module port01_pin_function_select_bench import pin_func_pkg::*;;
    // Routing tables: pin slot, selector code, function index
    localparam int IN_SLOT [14] = '{0, 1, 1, 9, 9, 9, 9, 10, 10, 10, 11, 11, 11, 11};
    localparam logic [5:0] IN_CODE [14] = '{6'h05, 6'h05, 6'h0a, 6'h05, 6'h0a, 6'h0b, 6'h10,
        6'h08, 6'h0b, 6'h0f, 6'h08, 6'h0a, 6'h0d, 6'h0f};
    localparam int IN_FN [14] = '{0, 1, 3, 2, 4, 7, 8, 9, 6, 11, 13, 5, 10, 12};
    localparam int OUT_SLOT [9] = '{0, 9, 10, 10, 10, 11, 11, 11, 11};
    localparam logic [5:0] OUT_CODE [9] = '{6'h0a, 6'h0b, 6'h0a, 6'h0d, 6'h0f, 6'h08, 6'h0a,
        6'h0b, 6'h0f};
    localparam int OUT_FN [9] = '{0, 4, 1, 5, 6, 8, 2, 3, 7};
    localparam int IRQ_EXP [12] = '{8, 9, 10, 11, 13, 15, 2, 3, 4, 5, 6, 7};
    localparam logic [7:0] BAD_CODE [5] = '{8'h00, 8'h01, 8'h05, 8'h3f, 8'h88};

    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [ADDR_W-1:0] regAddr = '0;
    logic [7:0] regWdata = 8'h00;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [NUM_PINS-1:0] extLevel = '0;
    logic [8:0] drvVal = '0;
    logic [8:0] drvOe = '0;
    wire [7:0] regRdata;
    wire [NUM_PINS-1:0] pinIn, pinOut, pinOe;
    wire [8:0] pOut, pOe;
    wire [NUM_PERIPH_IN-1:0] fIn;
    wire [NUM_IRQ-1:0] irqLine;
    int mismatches = 0;
    int checks_done = 0;

    // Clock
    always #2 clk = ~clk;

    port01_pin_function_select u_port01_pin_function_select (
        .clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
        .serial6Transmit(pOut[0]), .serial6TransmitOe(pOe[0]),
        .serial1Transmit(pOut[1]), .serial1TransmitOe(pOe[1]),
        .serial1ClockOut(pOut[2]), .serial1ClockOe(pOe[2]),
        .serial3Transmit(pOut[3]), .serial3TransmitOe(pOe[3]),
        .serial3ClockOut(pOut[4]), .serial3ClockOe(pOe[4]),
        .spiMasterOut(pOut[5]), .spiMasterOutOe(pOe[5]),
        .i2c2ClockOut(pOut[6]), .i2c2ClockOe(pOe[6]),
        .i2c2DataOut(pOut[7]), .i2c2DataOe(pOe[7]),
        .multitimer4bOut(pOut[8]), .multitimer4bOe(pOe[8]),
        .timer8Ch0ResetIn(fIn[0]), .timer8Ch0ClockIn(fIn[1]), .timer8Ch2ClockIn(fIn[2]),
        .serial6Receive(fIn[3]), .serial1Receive(fIn[4]), .serial1ClockIn(fIn[5]),
        .serial3Receive(fIn[6]), .serial3ClockIn(fIn[7]), .canReceive(fIn[8]),
        .adcTrigger0N(fIn[9]), .spiMasterIn(fIn[10]), .i2c2ClockIn(fIn[11]),
        .i2c2DataIn(fIn[12]), .multitimer4bIn(fIn[13]), .externalIrqLine(irqLine));

    pin_periph_model u_pin_periph_model (
        .clk(clk), .extLevel(extLevel), .drvVal(drvVal), .drvOe(drvOe),
        .pinOut(pinOut), .pinOe(pinOe), .pinIn(pinIn), .periphOut(pOut), .periphOe(pOe));

    // Comparison and bookkeeping
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Bus cycles
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        @(negedge clk);
        chk(regRdata, exp);
        @(negedge clk);
        chk(regRdata, 8'h00);
    endtask

    // Wait n edges, then sample mid-cycle
    task automatic look(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    // Watchdog
    initial begin
        repeat (40000) @(posedge clk);
        mismatches++;
        print_verdict();
    end

    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < NUM_PINS; i++) rd(PIN_ADDR[i], 8'h00);
        for (int i = 0; i < NUM_PINS; i++) wr(PIN_ADDR[i], 8'h80 | 8'(i * 5));
        wr(4'hc, 8'h5a);
        for (int i = 0; i < NUM_PINS; i++) rd(PIN_ADDR[i], 8'h80 | 8'(i * 5));
        rd(4'hc, 8'h00);
        rd(4'hf, 8'h00);
        for (int i = 0; i < NUM_PINS; i++) wr(PIN_ADDR[i], 8'h00);
        $display("test registers done");
        for (int i = 0; i < 14; i++) begin
            wr(PIN_ADDR[IN_SLOT[i]], {2'b00, IN_CODE[i]});
            for (int lv = 0; lv < 2; lv++) begin
                @(posedge clk);
                extLevel <= (lv == 1) ? (12'h1 << IN_SLOT[i]) : ~(12'h1 << IN_SLOT[i]);
                look(3);
                if (lv == 1) chk(fIn, PERIPH_IDLE | (14'h1 << IN_FN[i]));
                else chk(fIn, PERIPH_IDLE & ~(14'h1 << IN_FN[i]));
                chk(pinOe, 12'h000);
            end
            wr(PIN_ADDR[IN_SLOT[i]], 8'h00);
        end
        $display("test input routing done");
        for (int i = 0; i < 9; i++) begin
            wr(PIN_ADDR[OUT_SLOT[i]], {2'b00, OUT_CODE[i]});
            @(posedge clk);
            drvOe <= 9'h1 << OUT_FN[i];
            drvVal <= 9'h1 << OUT_FN[i];
            look(1);
            chk(pinOe, 12'h1 << OUT_SLOT[i]);
            chk(pinOut[OUT_SLOT[i]], 1'b1);
            @(posedge clk);
            drvVal <= '0;
            look(1);
            chk(pinOut[OUT_SLOT[i]], 1'b0);
            @(posedge clk);
            drvOe <= ~(9'h1 << OUT_FN[i]);
            drvVal <= '1;
            look(1);
            chk(pinOe, 12'h000);
            @(posedge clk);
            drvOe <= '0;
            wr(PIN_ADDR[OUT_SLOT[i]], 8'h00);
        end
        $display("test output routing done");
        @(posedge clk);
        drvOe <= '1;
        drvVal <= '1;
        extLevel <= '1;
        for (int s = 10; s < 12; s++) begin
            for (int i = 0; i < 5; i++) begin
                wr(PIN_ADDR[s], BAD_CODE[i]);
                look(3);
                chk(pinOe, 12'h000);
                chk(fIn, PERIPH_IDLE);
            end
            wr(PIN_ADDR[s], 8'h00);
        end
        @(posedge clk);
        drvOe <= '0;
        look(3);
        chk(irqLine, 16'h0000);
        $display("test reserved codes done");
        for (int i = 0; i < NUM_PINS; i++) begin
            wr(PIN_ADDR[i], 8'h40);
            look(2);
            chk(irqLine, 16'h1 << IRQ_EXP[i]);
            @(posedge clk);
            extLevel <= ~(12'h1 << i);
            look(3);
            chk(irqLine, 16'h0000);
            @(posedge clk);
            extLevel <= '1;
            wr(PIN_ADDR[i], 8'h00);
        end
        $display("test interrupt lines done");
        wr(PIN_ADDR[11], 8'h48);
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(PIN_ADDR[11], 8'h00);
        look(1);
        chk(irqLine, 16'h0000);
        $display("test second reset done");
        print_verdict();
    end
endmodule // port01_pin_function_select_bench
